// ===== hdl/slcr_top.sv
`timescale 1ns/1ps
`include "slcr_defs.svh"
// How it works
// - Packets are always 32 data bytes
// - Keyhole window, nine reads per packet
// - Header word first, then payload ascending
// - Flag clears after ninth; blocks capture
// - Rate code 0x0A or 0x06
// - Lane count one to four
// - Framing bit one when enhanced
// - Training codes 00, 01, 10
// - Quality pattern codes 00 to 11
module slcr_top (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire slcr_pkg::slcr_apb_t apb,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire slcr_pkg::slcr_pkt_t pkt_in,
    input  wire logic                pkt_valid,
    output logic                     pkt_ready,
    input  wire slcr_pkg::slcr_cfg_t cfg_in,
    input  wire logic                cfg_we,
    output logic                     irq
);

    // ==========================================
    // Bus phase decode

    // Setup cycle of a transfer
    wire setup  = apb.psel & ~apb.penable;
    // Access cycle; always zero wait
    wire access = apb.psel & apb.penable;
    // Completed write
    wire wr_acc = access & apb.pwrite;
    // Completed read
    wire rd_acc = access & ~apb.pwrite;
    // Read announced in setup
    wire rd_set = setup & ~apb.pwrite;

    // ==========================================
    // Address decode

    // Word aligned access
    wire aligned  = (apb.paddr[1:0] == 2'h0);
    // Inside the keyhole range
    wire in_win   = (apb.paddr >= `SLCR_WIN_LO) &
                    (apb.paddr <= `SLCR_WIN_HI);
    // Keyhole hit
    wire hit_win  = aligned & in_win;
    // Link rate readout
    wire hit_rate = (apb.paddr == `SLCR_RATE_OFF);
    // Lane count readout
    wire hit_lane = (apb.paddr == `SLCR_LANES_OFF);
    // Framing readout
    wire hit_frm  = (apb.paddr == `SLCR_FRAME_OFF);
    // Training readout
    wire hit_trn  = (apb.paddr == `SLCR_TRAIN_OFF);
    // Quality pattern readout
    wire hit_tst  = (apb.paddr == `SLCR_TEST_OFF);
    // Interrupt status
    wire hit_ist  = (apb.paddr == `SLCR_ISTAT_OFF);
    // Interrupt clear
    wire hit_icl  = (apb.paddr == `SLCR_ICLR_OFF);
    // Interrupt enable
    wire hit_ien  = (apb.paddr == `SLCR_IEN_OFF);
    // Any mapped word
    wire mapped   = hit_win | hit_rate | hit_lane |
                    hit_frm | hit_trn | hit_tst |
                    hit_ist | hit_icl | hit_ien;

    // ==========================================
    // Packet store

    logic [31:0] pkt_word; // Word at the pointer
    logic        pkt_full; // Packet waiting
    logic        pop;      // Advance the keyhole

    assign pop = rd_acc & hit_win;

    // Holds one packet until all words are read
    slcr_pkt_store #(
        .WORDS     (`SLCR_PKT_WORDS)
    ) u_store (
        .pclk      (pclk),
        .presetn   (presetn),
        .pkt_in    (pkt_in),
        .pkt_valid (pkt_valid),
        .pkt_ready (pkt_ready),
        .pop       (pop),
        .word      (pkt_word),
        .full      (pkt_full)
    );

    // ==========================================
    // Link settings mirror

    slcr_pkg::slcr_cfg_t cfg;     // Current settings
    logic                cfg_chg; // A field changed

    // Fed only by the transmitter side
    slcr_cfg_mirror u_mirror (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg_in  (cfg_in),
        .cfg_we  (cfg_we),
        .cfg     (cfg),
        .changed (cfg_chg)
    );

    // ==========================================
    // Interrupt registers

    localparam int NB = `SLCR_IRQ_BITS;

    logic [NB-1:0] ist_r;   // Sticky status
    logic [NB-1:0] ist_nxt; // Next status
    logic [NB-1:0] ien_r;   // Enable mask
    logic [NB-1:0] ev;      // Events this cycle
    logic [NB-1:0] clr;     // Software clear mask

    // A captured packet and a settings change
    assign ev[`SLCR_IRQ_PKT] = pkt_valid & pkt_ready;
    assign ev[`SLCR_IRQ_CFG] = cfg_chg;

    // Clear is write-one-to-clear
    assign clr = (wr_acc & hit_icl) ? apb.pwdata[NB-1:0] : '0;

    // Set after clear, so an event is never lost
    assign ist_nxt = (ist_r & ~clr) | ev;

    // Status and enable update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_r <= '0;
            ien_r <= '0;
        end else begin
            ist_r <= ist_nxt;
            if (wr_acc & hit_ien) begin
                ien_r <= apb.pwdata[NB-1:0];
            end
        end
    end

    // Level output while an enabled bit is set
    assign irq = |(ist_r & ien_r);

    // ==========================================
    // Read data selection

    logic [31:0] rd_mux; // Value for this address
    logic [31:0] prdata_r; // Registered read data

    wire [31:0] v_win  = pkt_word;
    wire [31:0] v_rate = {24'h0, cfg.rate};
    wire [31:0] v_lane = {27'h0, cfg.lanes};
    wire [31:0] v_frm  = {31'h0, cfg.enh};
    wire [31:0] v_trn  = {30'h0, cfg.tp};
    wire [31:0] v_tst  = {30'h0, cfg.lq};
    // Interrupt status and enable
    wire [31:0] v_ist  = {{(32-NB){1'b0}}, ist_r};
    wire [31:0] v_ien  = {{(32-NB){1'b0}}, ien_r};

    // Clear register reads as zero
    assign rd_mux = hit_win  ? v_win  :
                    hit_rate ? v_rate :
                    hit_lane ? v_lane :
                    hit_frm  ? v_frm  :
                    hit_trn  ? v_trn  :
                    hit_tst  ? v_tst  :
                    hit_ist  ? v_ist  :
                    hit_ien  ? v_ien  :
                    32'h0;

    // Capture in setup so the pop does not
    // disturb the word being returned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else if (rd_set) begin
            prdata_r <= rd_mux;
        end
    end

    // ==========================================
    // Bus answer

    // Zero wait states: ready in every access
    assign pready  = access;
    // Read data from the setup capture
    assign prdata  = prdata_r;
    // Error only for unmapped or misaligned;
    // writes to readouts complete quietly
    assign pslverr = access & ~mapped;

    // readout writes decode nowhere
    // No write path reaches the mirror or the
    // store; only the interrupt words take data.

    // ==========================================
    // Checks

    // Completed keyhole reads of the packet held now.
    // Counted apart from the store's pointer so that
    // the drain checks below do not trust the logic
    // that they are meant to watch.
    logic [3:0] pops_r; // Reads since capture

    // Restart on capture, count pops while pending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pops_r <= 4'h0;
        end else if (ev[`SLCR_IRQ_PKT]) begin
            pops_r <= 4'h0;
        end else if (pop & pkt_full) begin
            pops_r <= pops_r + 4'h1;
        end
    end

    // Keyhole read returns the word seen at setup
    property p_win_read;
        @(posedge pclk) disable iff (!presetn)
        rd_set && hit_win |=> prdata == $past(pkt_word);
    endproperty
    a_win_read: assert property (p_win_read) else $error("keyhole data wrong");

    // Framing readout shows the mirrored bit
    property p_frm_read;
        @(posedge pclk) disable iff (!presetn)
        rd_set && hit_frm |=> prdata == {31'h0, $past(cfg.enh)};
    endproperty
    a_frm_read: assert property (p_frm_read) else $error("framing readout wrong");

    // Training readout never shows the reserved code
    property p_trn_read;
        @(posedge pclk) disable iff (!presetn)
        rd_set && hit_trn |=> prdata[31:2] == 30'h0 && prdata[1:0] != `SLCR_TP_RSVD;
    endproperty
    a_trn_read: assert property (p_trn_read) else $error("training readout wrong");

    // A write to the keyhole does not move it
    property p_wr_ignore;
        @(posedge pclk) disable iff (!presetn)
        wr_acc && hit_win && !pkt_valid |=> $stable(pkt_word) && $stable(pkt_full);
    endproperty
    a_wr_ignore: assert property (p_wr_ignore) else $error("write moved keyhole");

    // A write to a readout leaves settings alone
    property p_cfg_ignore;
        @(posedge pclk) disable iff (!presetn)
        wr_acc && !cfg_we |=> $stable(cfg);
    endproperty
    a_cfg_ignore: assert property (p_cfg_ignore) else $error("write changed settings");

    // Ninth completed read drains a pending packet
    property p_nine;
        @(posedge pclk) disable iff (!presetn)
        pkt_full && pop && pops_r == 4'h8 |=> !pkt_full;
    endproperty
    a_nine: assert property (p_nine) else $error("packet not drained");

    // Event is kept even when cleared together
    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        ev[`SLCR_IRQ_PKT] |=> ist_r[`SLCR_IRQ_PKT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("packet event lost");

    // Fewer than nine reads keep the packet and the block
    property p_keep;
        @(posedge pclk) disable iff (!presetn)
        pkt_full && pops_r < 4'h8 |=> pkt_full && !pkt_ready;
    endproperty
    a_keep: assert property (p_keep) else $error("packet released early");

    // Rate readout shows the mirrored code
    property p_rate_read;
        @(posedge pclk) disable iff (!presetn)
        rd_set && hit_rate |=> prdata == {24'h0, $past(cfg.rate)};
    endproperty
    a_rate_read: assert property (p_rate_read) else $error("rate readout wrong");

    // Lane readout shows the mirrored count
    property p_lane_read;
        @(posedge pclk) disable iff (!presetn)
        rd_set && hit_lane |=> prdata == {27'h0, $past(cfg.lanes)};
    endproperty
    a_lane_read: assert property (p_lane_read) else $error("lane readout wrong");

    // Quality pattern readout shows the mirrored code
    property p_tst_read;
        @(posedge pclk) disable iff (!presetn)
        rd_set && hit_tst |=> prdata == {30'h0, $past(cfg.lq)};
    endproperty
    a_tst_read: assert property (p_tst_read) else $error("pattern readout wrong");

    // Status readout shows the sticky bits
    property p_ist_read;
        @(posedge pclk) disable iff (!presetn)
        rd_set && hit_ist |=> prdata == {{(32-NB){1'b0}}, $past(ist_r)};
    endproperty
    a_ist_read: assert property (p_ist_read) else $error("status readout wrong");

    // Enable readout shows the mask
    property p_ien_read;
        @(posedge pclk) disable iff (!presetn)
        rd_set && hit_ien |=> prdata == {{(32-NB){1'b0}}, $past(ien_r)};
    endproperty
    a_ien_read: assert property (p_ien_read) else $error("enable readout wrong");

    // Clear register is write only and reads zero
    property p_icl_read;
        @(posedge pclk) disable iff (!presetn)
        rd_set && hit_icl |=> prdata == 32'h0;
    endproperty
    a_icl_read: assert property (p_icl_read) else $error("clear readout not zero");

    // Unmapped or misaligned reads return zero
    property p_err_read;
        @(posedge pclk) disable iff (!presetn)
        rd_set && !mapped |=> prdata == 32'h0;
    endproperty
    a_err_read: assert property (p_err_read) else $error("unmapped read not zero");

    // A clear drops its status bit unless an event
    // arrives in the same cycle, which then wins
    for (genvar b = 0; b < NB; b++) begin : g_clr_chk
        property p_clr_bit;
            @(posedge pclk) disable iff (!presetn)
            clr[b] && !ev[b] |=> !ist_r[b];
        endproperty
        a_clr_bit: assert property (p_clr_bit) else $error("status bit not cleared");
    end

endmodule : slcr_top

// ===== hdl/slcr_defs.svh
`ifndef SLCR_DEFS_SVH
`define SLCR_DEFS_SVH
// ==========================================
// Register byte offsets
`define SLCR_WIN_LO     12'h330
`define SLCR_WIN_HI     12'h350
`define SLCR_RATE_OFF   12'h400
`define SLCR_LANES_OFF  12'h404
`define SLCR_FRAME_OFF  12'h408
`define SLCR_TRAIN_OFF  12'h40C
`define SLCR_TEST_OFF   12'h410
`define SLCR_ISTAT_OFF  12'h440
`define SLCR_ICLR_OFF   12'h444
`define SLCR_IEN_OFF    12'h448
// ==========================================
// Field codes and reset values
`define SLCR_RATE_HI    8'h0A
`define SLCR_RATE_LO    8'h06
`define SLCR_LANES_MIN  5'h01
`define SLCR_LANES_MAX  5'h04
`define SLCR_TP_RSVD    2'h3
`define SLCR_RATE_RST   8'h06
`define SLCR_LANES_RST  5'h01
// ==========================================
// Sizes and interrupt bit positions
`define SLCR_PKT_WORDS  9
`define SLCR_IRQ_BITS   2
`define SLCR_IRQ_PKT    0
`define SLCR_IRQ_CFG    1
`endif

// ===== hdl/slcr_pkg.sv
package slcr_pkg;
    // ==========================================
    // Captured packet, header in the low word
    typedef struct packed {
        logic [31:0][7:0] payload_byte; // [0] lowest
        logic [3:0][7:0]  header_byte;  // [0] lowest
    } slcr_pkt_t;
    // Link settings written by the transmitter
    typedef struct packed {
        logic [7:0] rate;  // Bandwidth code
        logic [4:0] lanes; // Enabled lanes
        logic       enh;   // Enhanced framing
        logic [1:0] tp;    // Training pattern
        logic [1:0] lq;    // Quality pattern
    } slcr_cfg_t;
    // APB request from the master
    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } slcr_apb_t;
endpackage : slcr_pkg

// ===== hdl/slcr_pkt_store.sv
`timescale 1ns/1ps
`include "slcr_defs.svh"
module slcr_pkt_store #(
    parameter int WORDS = `SLCR_PKT_WORDS
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire slcr_pkg::slcr_pkt_t pkt_in,
    input  wire logic                pkt_valid,
    output logic                     pkt_ready,
    input  wire logic                pop,
    output logic [31:0]              word,
    output logic                     full
);
    // Layout is fixed at nine words
    if (WORDS != 9) begin : g_chk
        $error("WORDS must be 9");
    end
    logic [WORDS-1:0][31:0] mem_r;  // Packet words
    logic [3:0]             idx_r;  // Keyhole pointer
    logic                   full_r; // Packet pending
    wire take = pkt_valid & ~full_r;
    wire last = (idx_r == 4'(WORDS - 1));
    // ==========================================
    // Capture and keyhole pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_r  <= '0;
            idx_r  <= 4'h0;
            full_r <= 1'b0;
        end else if (take) begin
            mem_r  <= pkt_in;
            idx_r  <= 4'h0;
            full_r <= 1'b1;
        end else if (pop & full_r) begin
            idx_r  <= last ? 4'h0 : idx_r + 4'h1;
            full_r <= ~last;
        end
    end
    assign pkt_ready = ~full_r;
    assign word = full_r ? mem_r[idx_r] : 32'h0;
    assign full = full_r;
    property p_ps_full;
        @(posedge pclk) disable iff (!presetn)
        full_r && pop && last |=> !full_r && pkt_ready;
    endproperty
    a_ps_full: assert property (p_ps_full) else $error("flag not cleared");
    property p_ps_hdr;
        @(posedge pclk) disable iff (!presetn)
        take |=> word[7:0] == $past(pkt_in.header_byte[0]) && word[31:24] == $past(pkt_in.header_byte[3]);
    endproperty
    a_ps_hdr: assert property (p_ps_hdr) else $error("header word wrong");
    property p_ps_step;
        @(posedge pclk) disable iff (!presetn)
        full_r && pop && !last |=> idx_r == $past(idx_r) + 4'h1 && full_r;
    endproperty
    a_ps_step: assert property (p_ps_step) else $error("keyhole no step");
endmodule : slcr_pkt_store

// ===== hdl/slcr_cfg_mirror.sv
`timescale 1ns/1ps
`include "slcr_defs.svh"
module slcr_cfg_mirror (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire slcr_pkg::slcr_cfg_t cfg_in,
    input  wire logic                cfg_we,
    output slcr_pkg::slcr_cfg_t      cfg,
    output logic                     changed
);
    slcr_pkg::slcr_cfg_t cfg_r;   // Mirrored settings
    slcr_pkg::slcr_cfg_t cfg_nxt; // Filtered update
    logic                chg_r;   // Change pulse
    // Invalid codes keep the previous value
    wire rate_ok = (cfg_in.rate == `SLCR_RATE_HI) | (cfg_in.rate == `SLCR_RATE_LO);
    wire lane_ok = (cfg_in.lanes >= `SLCR_LANES_MIN) & (cfg_in.lanes <= `SLCR_LANES_MAX);
    assign cfg_nxt.rate  = rate_ok ? cfg_in.rate : cfg_r.rate;
    assign cfg_nxt.lanes = lane_ok ? cfg_in.lanes : cfg_r.lanes;
    assign cfg_nxt.enh   = cfg_in.enh;
    assign cfg_nxt.tp    = (cfg_in.tp != `SLCR_TP_RSVD) ? cfg_in.tp : cfg_r.tp;
    assign cfg_nxt.lq    = cfg_in.lq;
    // ==========================================
    // Mirror update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= '{rate: `SLCR_RATE_RST, lanes: `SLCR_LANES_RST, default: '0};
            chg_r <= 1'b0;
        end else begin
            chg_r <= cfg_we & (cfg_nxt != cfg_r);
            if (cfg_we) begin
                cfg_r <= cfg_nxt;
            end
        end
    end
    assign cfg     = cfg_r;
    assign changed = chg_r;
    property p_cm_codes;
        @(posedge pclk) disable iff (!presetn)
        (cfg_r.rate == `SLCR_RATE_HI || cfg_r.rate == `SLCR_RATE_LO) && cfg_r.tp != `SLCR_TP_RSVD;
    endproperty
    a_cm_codes: assert property (p_cm_codes) else $error("bad rate or pattern");
    property p_cm_lanes;
        @(posedge pclk) disable iff (!presetn)
        cfg_r.lanes >= `SLCR_LANES_MIN && cfg_r.lanes <= `SLCR_LANES_MAX;
    endproperty
    a_cm_lanes: assert property (p_cm_lanes) else $error("lane count out of range");
    property p_cm_lq;
        @(posedge pclk) disable iff (!presetn)
        cfg_we |=> cfg_r.lq == $past(cfg_in.lq) && cfg_r.enh == $past(cfg_in.enh);
    endproperty
    a_cm_lq: assert property (p_cm_lq) else $error("pattern not mirrored");
endmodule : slcr_cfg_mirror

// ===== testbench/slcr_src_model.sv
`timescale 1ns/1ps
// ==========================================
// Transmitter-side stand-in: offers packets and link settings
module slcr_src_model (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                pkt_go,    // Request one packet
    input  wire logic [7:0]          seed,      // First byte of the pattern
    input  wire logic                cfg_go,    // Request one settings write
    input  wire slcr_pkg::slcr_cfg_t cfg_val,   // Settings to write
    input  wire logic                pkt_ready,
    output slcr_pkg::slcr_pkt_t      pkt_in,
    output logic                     pkt_valid,
    output slcr_pkg::slcr_cfg_t      cfg_in,
    output logic                     cfg_we
);
    // Offer is held until taken, so a refused packet waits, not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_valid <= 1'b0;
            pkt_in    <= '0;
        end else if (pkt_go) begin
            pkt_valid <= 1'b1;
            for (int i = 0; i < 36; i++) begin
                pkt_in[8*i+:8] <= seed + 8'(i);
            end
        end else if (pkt_valid && pkt_ready) begin
            pkt_valid <= 1'b0;
            // Released bus flips, so stale data cannot pass
            pkt_in    <= ~pkt_in;
        end
    end

    // One-cycle settings strobe; data inverted outside it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_we <= 1'b0;
            cfg_in <= '0;
        end else begin
            cfg_we <= cfg_go;
            cfg_in <= cfg_go ? cfg_val : ~cfg_in;
        end
    end
endmodule : slcr_src_model

// ===== testbench/tb_sink_link_config_readout.sv
`timescale 1ns/1ps
module tb_sink_link_config_readout;
    // ==========================================
    // Signals
    logic                pclk, presetn, pready, pslverr, pkt_valid, pkt_ready;
    logic                cfg_we, irq, pkt_go, cfg_go;
    logic [31:0]         prdata;
    logic [7:0]          seed;
    slcr_pkg::slcr_apb_t apb;
    slcr_pkg::slcr_pkt_t pkt_in;
    slcr_pkg::slcr_cfg_t cfg_in, cfg_val;
    int                  fail_count = 0;
    int                  checks = 0;

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    slcr_top i_slcr_top (.pclk(pclk), .presetn(presetn), .apb(apb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pkt_in(pkt_in), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
        .cfg_in(cfg_in), .cfg_we(cfg_we), .irq(irq));
    slcr_src_model i_slcr_src_model (.pclk(pclk), .presetn(presetn), .pkt_go(pkt_go), .seed(seed),
        .cfg_go(cfg_go), .cfg_val(cfg_val), .pkt_ready(pkt_ready), .pkt_in(pkt_in),
        .pkt_valid(pkt_valid), .cfg_in(cfg_in), .cfg_we(cfg_we));

    // ==========================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; waits for pready, the watchdog ends a hang
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        apb.paddr   <= a;
        apb.pwrite  <= w;
        apb.pwdata  <= d;
        apb.psel    <= 1'b1;
        apb.penable <= 1'b0;
        @(posedge pclk);
        apb.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        apb.psel    <= 1'b0;
        apb.penable <= 1'b0;
        // Status launched at the access edge settles before callers look
        @(posedge pclk);
    endtask : xfer

    // Read expecting a clean answer
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        xfer(a, 1'b0, 32'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, 32'h0);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic eexp);
        logic [31:0] q;
        logic        e;
        xfer(a, 1'b1, d, q, e);
        chk({31'h0, e}, {31'h0, eexp});
    endtask : wr

    task automatic set_cfg(input slcr_pkg::slcr_cfg_t v);
        @(posedge pclk);
        cfg_val <= v;
        cfg_go  <= 1'b1;
        @(posedge pclk);
        cfg_go  <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : set_cfg

    task automatic cfg_all(input slcr_pkg::slcr_cfg_t e);
        rd(12'h400, {24'h0, e.rate});
        rd(12'h404, {27'h0, e.lanes});
        rd(12'h408, {31'h0, e.enh});
        rd(12'h40C, {30'h0, e.tp});
        rd(12'h410, {30'h0, e.lq});
    endtask : cfg_all

    task automatic send(input logic [7:0] s);
        @(posedge pclk);
        seed   <= s;
        pkt_go <= 1'b1;
        @(posedge pclk);
        pkt_go <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : send

    // Nine keyhole reads, each at a different aligned address
    task automatic drain(input logic [7:0] s);
        logic [31:0] w;
        for (int k = 0; k < 9; k++) begin
            for (int j = 0; j < 4; j++) begin
                w[8*j+:8] = s + 8'(4 * k + j);
            end
            rd(12'h330 + 12'(4 * k), w);
        end
    endtask : drain

    // ==========================================
    // Scenarios
    task automatic t_cfg;
        slcr_pkg::slcr_cfg_t e, v;
        e = '{rate: 8'h06, lanes: 5'h01, enh: 1'b0, tp: 2'h0, lq: 2'h0};
        cfg_all(e);
        // Every code of each field; code 3 of training is reserved
        for (int k = 0; k < 4; k++) begin
            v = '{rate: (k[0] ? 8'h0A : 8'h06), lanes: 5'(k + 1), enh: k[0], tp: 2'(k), lq: 2'(k)};
            set_cfg(v);
            e = v;
            if (k == 3) e.tp = 2'h2;
            cfg_all(e);
            if (k < 2) rd(12'h440, (k == 1) ? 32'h2 : 32'h0);
        end
        // Invalid rate and lane codes keep the old values
        for (int k = 0; k < 2; k++) begin
            v = e;
            v.rate = 8'h14;
            v.lanes = k[0] ? 5'h05 : 5'h00;
            set_cfg(v);
            cfg_all(e);
        end
        wr(12'h400, 32'hFFFF_FFFF, 1'b0);
        wr(12'h40C, 32'h0000_0001, 1'b0);
        cfg_all(e);
        wr(12'h448, 32'h2, 1'b0);
        chk({31'h0, irq}, 32'h1);
        wr(12'h444, 32'h2, 1'b0);
        chk({31'h0, irq}, 32'h0);
        rd(12'h448, 32'h2);
        rd(12'h444, 32'h0);
    endtask : t_cfg

    task automatic t_pkt;
        logic [31:0] q;
        logic        e;
        wr(12'h448, 32'h1, 1'b0);
        send(8'h10);
        chk({31'h0, pkt_ready}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        send(8'h80);
        chk({31'h0, pkt_ready}, 32'h0);
        wr(12'h330, 32'hA5A5_A5A5, 1'b0);
        drain(8'h10);
        drain(8'h80);
        chk({31'h0, pkt_ready}, 32'h1);
        rd(12'h334, 32'h0);
        rd(12'h440, 32'h1);
        wr(12'h444, 32'h1, 1'b0);
        chk({31'h0, irq}, 32'h0);
        xfer(12'h500, 1'b0, 32'h0, q, e);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        xfer(12'h402, 1'b0, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
    endtask : t_pkt

    // ==========================================
    // Verdict and hang guard
    task automatic wrap_up;
        if (fail_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    initial begin
        #50us;
        fail_count++;
        wrap_up();
    end

    initial begin
        apb     = '0;
        pkt_go  = 1'b0;
        cfg_go  = 1'b0;
        seed    = 8'h00;
        cfg_val = '0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, pkt_ready}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        t_cfg();
        t_pkt();
        wrap_up();
    end
endmodule : tb_sink_link_config_readout
